//--- rtl/rtcc_ctrl.sv
/*
 * Control, status and interrupt logic of the real time clock: host index and
 * data ports, control registers, divider chain, update timing, flags and the
 * wake/kickstart power output.
 * Assumes host strobes, oscillator and supply pins are asynchronous; time and
 * alarm bytes and wake_event come from clk_sys logic. nrst marks first power-up.
 */
// Summary of operation
// - Extended registers at 4AH/4BH in bank one
// - Divider bits choose run, chain reset, or stop
// - First update 500 ms after run pattern
// - Rate select picks divider tap or none
// - Periodic flag sets regardless; enable gates interrupt
// - Alarm flag on match, 11XXXXXX matches all
// - Update inhibit rising clears update interrupt enable
// - Data format bit read/write, binary or BCD
// - Hour format bit read/write, 24 or 12
// - Daylight saving enable drives special updates
// - Any flag is OR of enabled flags
// - Reading flag register clears three flags
// - Periodic on tap edge, update flag after update
// - Unused flag and battery bits read zero
// - Battery valid read-only, reports backup battery
// - Busy 122 ms before update; aux presence bit
// - Power control writable, cleared by enabled events
// - Wake/kick flags set by event, cleared by zero
// - Power fail tristates power pin unless hold
// - Enables gate wake/kick onto both pins
// - First power-up initialises extended control bits
// - Every power-on forces oscillator on, chain running
// - Index port 70H then data port 71H
// - Read-clear flags latched; events held until read ends
`timescale 1ns/1ps

module rtcc_ctrl #(
    parameter int UPD_CYCLES = 16
) (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic [15:0]          io_addr,
    input  wire logic                 io_rd_n,
    input  wire logic                 io_wr_n,
    input  wire logic [7:0]           io_wdata,
    output logic      [7:0]           io_rdata,
    output logic                      io_rdata_oe,
    input  wire logic                 osc_32k,
    input  wire logic                 vcc_ok,
    input  wire logic                 backup_battery_good,
    input  wire logic                 aux_supply,
    input  wire logic                 kick_in_n,
    input  wire logic                 wake_event,
    input  wire rtcc_pkg::rtcc_time_s cur_time,
    input  wire rtcc_pkg::rtcc_time_s alarm_time,
    output rtcc_pkg::rtcc_mode_s      mode,
    output logic                      irq_out_n,
    output logic                      power_out_n,
    output logic                      power_out_oe
);
    import rtcc_pkg::*;

    initial begin
        if (UPD_CYCLES < 1 || UPD_CYCLES > 255) begin
            $error("UPD_CYCLES must lie in 1..255");
        end
    end

    localparam logic [7:0] UPD_LAST = 8'(UPD_CYCLES - 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]    rd_s;
        logic [1:0]    wr_s;
        logic [1:0]    osc_s;
        logic [1:0]    vcc_s;
        logic [1:0]    kick_s;
        logic [1:0]    batt_s;
        logic [1:0]    aux_s;
        logic          rd_q;
        logic          wr_q;
        logic          osc_q;
        logic          vcc_q;
        logic          kick_q;
        logic [6:0]    index;
        rtcc_reg_a_s   ra;
        rtcc_reg_b_s   rb;
        rtcc_ext_a_s   xa;
        rtcc_ext_b_s   xb;
        logic          periodic_flag;
        logic          alarm_flag;
        logic          update_flag;
        logic [2:0]    pend;
        logic          rd_c;
        logic [7:0]    rdata;
        logic          rd_oe;
        logic [14:0]   div;
        logic          tap_q;
        rtcc_upd_e     upd;
        logic [7:0]    ucnt;
        logic          upd_tick;
    } rtcc_state_s;

    localparam rtcc_state_s RST_STATE = '{
        rd_s: 2'h3, wr_s: 2'h3, osc_s: 2'h0, vcc_s: 2'h0, kick_s: 2'h3,
        batt_s: 2'h0, aux_s: 2'h0, rd_q: 1'b1, wr_q: 1'b1, osc_q: 1'b0,
        vcc_q: 1'b0, kick_q: 1'b1, index: 7'h00, ra: RST_A, rb: RST_B,
        xa: RST_XA, xb: RST_XB, periodic_flag: 1'b0, alarm_flag: 1'b0,
        update_flag: 1'b0, pend: 3'h0, rd_c: 1'b0, rdata: 8'h00,
        rd_oe: 1'b0, div: 15'h0000, tap_q: 1'b0, upd: RTCC_IDLE,
        ucnt: 8'h00, upd_tick: 1'b0
    };

    rtcc_state_s st;
    rtcc_state_s next_st;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Divider bit whose rising edge is the periodic event; 15 means none
    function automatic logic [3:0] tap_bit(input logic [3:0] rs);
        case (rs)
            4'h0:    tap_bit = 4'hf;
            4'h1:    tap_bit = 4'h6;
            4'h2:    tap_bit = 4'h7;
            default: tap_bit = 4'(rs - 4'h2);
        endcase
    endfunction : tap_bit

    function automatic logic byte_match(input logic [7:0] t, input logic [7:0] a);
        byte_match = (a[7:6] == 2'b11) || (a == t);
    endfunction : byte_match

    function automatic logic run_pattern(input rtcc_reg_a_s r);
        run_pattern = !r.chain_reset && r.oscillator_on;
    endfunction : run_pattern

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic        rd_start;
    logic        rd_end;
    logic        wr_start;
    logic        osc_tick;
    logic        power_on;
    logic        kick_evt;
    logic        host_ok;
    logic        data_port;
    logic        ext_sel;
    logic        tap_now;
    logic        per_evt;
    logic        upd_evt;
    logic        alm_evt;
    logic        any_irq_flag;
    logic        c_hold;
    logic [3:0]  tap;
    logic [7:0]  reg_read;
    logic [14:0] div_inc;
    rtcc_reg_a_s wa;
    rtcc_reg_b_s wb;
    rtcc_ext_a_s wxa;

    always_comb begin
        next_st = st;
        next_st.rd_s   = {st.rd_s[0], io_rd_n};
        next_st.wr_s   = {st.wr_s[0], io_wr_n};
        next_st.osc_s  = {st.osc_s[0], osc_32k};
        next_st.vcc_s  = {st.vcc_s[0], vcc_ok};
        next_st.kick_s = {st.kick_s[0], kick_in_n};
        next_st.batt_s = {st.batt_s[0], backup_battery_good};
        next_st.aux_s  = {st.aux_s[0], aux_supply};
        next_st.rd_q   = st.rd_s[1];
        next_st.wr_q   = st.wr_s[1];
        next_st.osc_q  = st.osc_s[1];
        next_st.vcc_q  = st.vcc_s[1];
        next_st.kick_q = st.kick_s[1];
        next_st.upd_tick = 1'b0;

        host_ok   = st.vcc_s[1];
        rd_start  = host_ok && st.rd_q && !st.rd_s[1];
        rd_end    = !st.rd_q && st.rd_s[1];
        wr_start  = host_ok && st.wr_q && !st.wr_s[1];
        osc_tick  = !st.osc_q && st.osc_s[1];
        power_on  = !st.vcc_q && st.vcc_s[1];
        kick_evt  = st.kick_q && !st.kick_s[1];
        data_port = (io_addr == PORT_DATA);
        ext_sel   = st.ra.bank_select;

        // ------------------------------------------------------------
        // Divider chain and update timing
        // ------------------------------------------------------------
        div_inc = st.div + 15'h0001;
        per_evt = 1'b0;
        upd_evt = 1'b0;
        alm_evt = 1'b0;
        if (st.ra.chain_reset && st.ra.oscillator_on) begin
            next_st.div = 15'h0000;
        end else if (run_pattern(st.ra) && osc_tick) begin
            next_st.div = div_inc;
        end
        tap     = tap_bit(st.ra.rate_select);
        tap_now = (tap != 4'hf) && next_st.div[tap];
        next_st.tap_q = tap_now;
        per_evt = tap_now && !st.tap_q;

        case (st.upd)
            RTCC_IDLE: begin
                if (run_pattern(st.ra) && osc_tick && !st.rb.update_inhibit && div_inc == LEAD_POINT) begin
                    next_st.upd = RTCC_LEAD;
                end
            end
            RTCC_LEAD: begin
                if (st.rb.update_inhibit || !run_pattern(st.ra)) begin
                    next_st.upd = RTCC_IDLE;
                end else if (osc_tick && st.div == DIV_LAST) begin
                    next_st.upd      = RTCC_UPD;
                    next_st.ucnt     = 8'h00;
                    next_st.upd_tick = 1'b1;
                end
            end
            RTCC_UPD: begin
                next_st.ucnt = st.ucnt + 8'h01;
                if (st.ucnt == UPD_LAST) begin
                    next_st.upd = RTCC_IDLE;
                    upd_evt     = 1'b1;
                    alm_evt     = byte_match(cur_time.sec, alarm_time.sec) &&
                                  byte_match(cur_time.min, alarm_time.min) &&
                                  byte_match(cur_time.hour, alarm_time.hour);
                end
            end
            default: begin
                next_st.upd = RTCC_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // Host ports
        // ------------------------------------------------------------
        case (st.index)
            IDX_A:   reg_read = {(st.upd != RTCC_IDLE), st.ra};
            IDX_B:   reg_read = {st.rb[7:4], 1'b0, st.rb[2:0]};
            IDX_C:   reg_read = {any_irq_flag, st.periodic_flag, st.alarm_flag, st.update_flag, 4'h0};
            IDX_D:   reg_read = {st.batt_s[1], 7'h00};
            IDX_XA:  reg_read = ext_sel ? {st.aux_s[1], (st.upd != RTCC_IDLE), st.xa} : 8'h00;
            IDX_XB:  reg_read = ext_sel ? st.xb : 8'h00;
            default: reg_read = 8'h00;
        endcase

        if (rd_start && data_port) begin
            next_st.rdata = reg_read;
            next_st.rd_oe = 1'b1;
            next_st.rd_c  = (st.index == IDX_C);
        end else if (rd_start && io_addr == PORT_INDEX) begin
            next_st.rdata = {1'b0, st.index};
            next_st.rd_oe = 1'b1;
        end else if (rd_end) begin
            next_st.rd_oe = 1'b0;
            next_st.rd_c  = 1'b0;
        end

        // Flag register: captured at read start, events parked until read end
        // An event in the capture cycle is parked too, else the clear loses it
        c_hold = st.rd_c || (rd_start && data_port && st.index == IDX_C);
        if (c_hold) begin
            next_st.pend = st.pend | {per_evt, alm_evt, upd_evt};
            if (rd_end) begin
                next_st.periodic_flag = st.pend[2] | per_evt;
                next_st.alarm_flag    = st.pend[1] | alm_evt;
                next_st.update_flag   = st.pend[0] | upd_evt;
                next_st.pend          = 3'h0;
            end
        end else begin
            next_st.periodic_flag = st.periodic_flag | per_evt;
            next_st.alarm_flag    = st.alarm_flag | alm_evt;
            next_st.update_flag   = st.update_flag | upd_evt;
        end

        wa  = io_wdata[6:0];
        wb  = io_wdata;
        wxa = io_wdata[5:0];
        next_st.xa.wake_flag = st.xa.wake_flag | wake_event;
        next_st.xa.kick_flag = st.xa.kick_flag | kick_evt;
        if (wr_start && io_addr == PORT_INDEX) begin
            next_st.index = io_wdata[6:0];
        end else if (wr_start && data_port) begin
            case (st.index)
                IDX_A: begin
                    next_st.ra = wa;
                    if (run_pattern(wa) && !run_pattern(st.ra)) begin
                        next_st.div = FIRST_LOAD;
                        next_st.upd = RTCC_IDLE;
                    end
                end
                IDX_B: begin
                    next_st.rb       = wb;
                    next_st.rb.rsvd3 = 1'b0;
                    if (wb.update_inhibit && !st.rb.update_inhibit) begin
                        next_st.rb.update_irq_en = 1'b0;
                    end
                    if (wb.update_inhibit) begin
                        next_st.upd = RTCC_IDLE;
                    end
                end
                IDX_XA: begin
                    if (ext_sel) begin
                        next_st.xa.rsvd54        = wxa.rsvd54;
                        next_st.xa.rsvd2         = wxa.rsvd2;
                        next_st.xa.power_out_ctl = wxa.power_out_ctl;
                        next_st.xa.wake_flag     = wxa.wake_flag | wake_event;
                        next_st.xa.kick_flag     = wxa.kick_flag | kick_evt;
                    end
                end
                IDX_XB: begin
                    if (ext_sel) begin
                        next_st.xb = io_wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // Enabled wake or kick pulls the power output active
        if ((st.xa.wake_flag && st.xb.wake_irq_en) || (st.xa.kick_flag && st.xb.kick_irq_en)) begin
            next_st.xa.power_out_ctl = 1'b0;
        end

        if (power_on) begin
            next_st.ra.oscillator_on = 1'b1;
            next_st.ra.chain_reset   = 1'b0;
        end
    end

    // Level seen by software and by the pin
    assign any_irq_flag = (st.periodic_flag && st.rb.periodic_irq_en) ||
                          (st.alarm_flag && st.rb.alarm_irq_en) ||
                          (st.update_flag && st.rb.update_irq_en) ||
                          (st.xa.wake_flag && st.xb.wake_irq_en) ||
                          (st.xa.kick_flag && st.xb.kick_irq_en);

    // ----------------------------------------------------------------
    // Registers; nrst only on first power-up, battery holds the rest
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign io_rdata    = st.rdata;
    assign io_rdata_oe = st.rd_oe;

    // Interrupt pin needs main power; wake/kick still reach the power pin
    assign irq_out_n    = !(any_irq_flag && st.vcc_s[1]);
    assign power_out_n  = st.xa.power_out_ctl;
    assign power_out_oe = st.vcc_s[1] || st.xb.powerfail_pin_hold;

    assign mode.data_format = st.rb.data_format;
    assign mode.hour_format = st.rb.hour_format;
    assign mode.dst_enable  = st.rb.dst_enable;
    assign mode.bank_select = st.ra.bank_select;
    assign mode.crystal_sel = st.xb.crystal_sel;
    assign mode.aux_batt_en = st.xb.aux_batt_en;
    assign mode.osc_running = st.ra.oscillator_on;
    assign mode.update_tick = st.upd_tick;

endmodule : rtcc_ctrl

//--- common/rtcc_pkg.sv
/*
 * Constants, register layouts and carrier types for the real time clock
 * control, status and interrupt block.
 * Assumes a 200 MHz system clock and a 32.768 kHz timekeeping oscillator.
 */
package rtcc_pkg;

    // ----------------------------------------------------------------
    // Host ports and register indices
    // ----------------------------------------------------------------
    localparam logic [15:0] PORT_INDEX = 16'h0070;
    localparam logic [15:0] PORT_DATA  = 16'h0071;
    localparam logic [6:0]  IDX_A      = 7'h0a;
    localparam logic [6:0]  IDX_B      = 7'h0b;
    localparam logic [6:0]  IDX_C      = 7'h0c;
    localparam logic [6:0]  IDX_D      = 7'h0d;
    localparam logic [6:0]  IDX_XA     = 7'h4a;
    localparam logic [6:0]  IDX_XB     = 7'h4b;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          OSC_HZ       = 32768;
    localparam int          LEAD_MS      = 122;
    localparam int          FIRST_UPD_MS = 500;
    localparam int          DIV_BITS     = 15;
    localparam logic [14:0] LEAD_POINT   = 15'(OSC_HZ - (LEAD_MS * OSC_HZ) / 1000);
    localparam logic [14:0] FIRST_LOAD   = 15'(OSC_HZ - (FIRST_UPD_MS * OSC_HZ) / 1000);
    localparam logic [14:0] DIV_LAST     = 15'h7fff;

    // ----------------------------------------------------------------
    // Register layouts and reset values
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       chain_reset;
        logic       oscillator_on;
        logic       bank_select;
        logic [3:0] rate_select;
    } rtcc_reg_a_s;

    typedef struct packed {
        logic update_inhibit;
        logic periodic_irq_en;
        logic alarm_irq_en;
        logic update_irq_en;
        logic rsvd3;
        logic data_format;
        logic hour_format;
        logic dst_enable;
    } rtcc_reg_b_s;

    typedef struct packed {
        logic [1:0] rsvd54;
        logic       power_out_ctl;
        logic       rsvd2;
        logic       wake_flag;
        logic       kick_flag;
    } rtcc_ext_a_s;

    typedef struct packed {
        logic aux_batt_en;
        logic rsvd6;
        logic crystal_sel;
        logic rsvd4;
        logic powerfail_pin_hold;
        logic rsvd2;
        logic wake_irq_en;
        logic kick_irq_en;
    } rtcc_ext_b_s;

    localparam rtcc_reg_a_s RST_A  = 7'h20;
    localparam rtcc_reg_b_s RST_B  = 8'h00;
    localparam rtcc_ext_a_s RST_XA = 6'h08;
    localparam rtcc_ext_b_s RST_XB = 8'ha9;

    typedef enum logic [1:0] {
        RTCC_IDLE = 2'b00,
        RTCC_LEAD = 2'b01,
        RTCC_UPD  = 2'b10
    } rtcc_upd_e;

    // Controls handed to the time and calendar counters
    typedef struct packed {
        logic data_format;
        logic hour_format;
        logic dst_enable;
        logic bank_select;
        logic crystal_sel;
        logic aux_batt_en;
        logic osc_running;
        logic update_tick;
    } rtcc_mode_s;

    // Time and alarm bytes from the counters
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
    } rtcc_time_s;

endpackage : rtcc_pkg

//--- dv/rtcc_ctrl_sva.sv
/*
 * Port-level checker for rtcc_ctrl, bound into every instance.
 * Assumes host strobes change just after a clk_sys edge.
 */
`timescale 1ns/1ps

module rtcc_ctrl_sva
    import rtcc_pkg::*;
#(
    parameter int UPD_CYCLES = 16
) (
    input wire logic                 clk_sys,
    input wire logic                 nrst,
    input wire logic                 io_rd_n,
    input wire logic                 io_wr_n,
    input wire logic                 vcc_ok,
    input wire logic [7:0]           io_rdata,
    input wire logic                 io_rdata_oe,
    input wire rtcc_pkg::rtcc_mode_s mode,
    input wire logic                 irq_out_n,
    input wire logic                 power_out_n,
    input wire logic                 power_out_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_reset_state: assert property ($rose(nrst) |-> irq_out_n && power_out_n && power_out_oe && !io_rdata_oe
        && mode.osc_running && mode.crystal_sel && mode.aux_batt_en) else $error("bad state after reset");
    a_read_answer: assert property ($fell(io_rd_n) && vcc_ok |-> ##[1:5] io_rdata_oe)
        else $error("read not answered");
    a_oe_release: assert property (io_rd_n[*6] |-> !io_rdata_oe) else $error("read enable stuck");
    a_rdata_hold: assert property ($changed(io_rdata) |-> $rose(io_rdata_oe)) else $error("read data moved");
    a_irq_needs_vcc: assert property (!vcc_ok[*4] |-> irq_out_n) else $error("irq without main power");
    a_pwr_oe_hold: assert property (vcc_ok[*5] |-> power_out_oe) else $error("power pin released");
    a_pwr_rise_write: assert property (io_wr_n[*6] |-> !$rose(power_out_n)) else $error("power pin rose alone");
    a_irq_rise_host: assert property ((io_rd_n && io_wr_n && vcc_ok)[*7] |-> !$rose(irq_out_n))
        else $error("irq released without host access");
    a_tick_pulse: assert property (mode.update_tick |=> !mode.update_tick) else $error("update tick too long");
endmodule : rtcc_ctrl_sva

bind rtcc_ctrl rtcc_ctrl_sva #(.UPD_CYCLES(UPD_CYCLES)) u_sva (.clk_sys, .nrst, .io_rd_n, .io_wr_n, .vcc_ok,
    .io_rdata, .io_rdata_oe, .mode, .irq_out_n, .power_out_n, .power_out_oe);

//--- dv/rtcc_host.sv
/*
 * Host model: index/data port cycles on the I/O strobes.
 * Assumes the caller waits for main power before calling.
 */
`timescale 1ns/1ps

module rtcc_host
    import rtcc_pkg::*;
(
    input wire logic  clk_sys,
    output logic [15:0] io_addr,
    output logic        io_rd_n,
    output logic        io_wr_n,
    output logic [7:0]  io_wdata
);
    initial begin
        io_addr = 16'h0000;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        io_wdata = 8'h00;
    end

    // Strobe low six clocks, high six: margin over the synchroniser
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rd_op);
        @(posedge clk_sys);
        #1;
        io_addr = a;
        io_wdata = d;
        if (rd_op) io_rd_n = 1'b0;
        else io_wr_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        io_wdata = ~d;
        repeat (6) @(posedge clk_sys);
    endtask : cyc

    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        cyc(PORT_INDEX, {1'b0, i}, 1'b0);
        cyc(PORT_DATA, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [6:0] i);
        cyc(PORT_INDEX, {1'b0, i}, 1'b0);
        cyc(PORT_DATA, ~io_wdata, 1'b1);
    endtask : rd
endmodule : rtcc_host

//--- dv/rtcc_ctrl_bench.sv
/*
 * Self-checking bench for rtcc_ctrl with a host model on the ports.
 * Assumes a fast oscillator so the first update lands within the run.
 */
`timescale 1ns/1ps

module rtcc_ctrl_bench;
    import rtcc_pkg::*;
    logic       clk_sys = 1'b0, nrst = 1'b0, osc_32k = 1'b0, vcc_ok = 1'b1, kick_in_n = 1'b1;
    logic       wake_event = 1'b0, backup_battery_good = 1'b1, aux_supply = 1'b1, oe_q = 1'b0;
    logic       io_rd_n, io_wr_n, io_rdata_oe, irq_out_n, power_out_n, power_out_oe;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, r;
    rtcc_time_s cur_time = '0, alarm_time = '0;
    rtcc_mode_s mode;
    int         failures = 0, total_checks = 0, n;
    logic [7:0] exq[$];

    always #2.5 clk_sys = ~clk_sys;
    always #10.3 osc_32k = ~osc_32k;

    rtcc_host host (.clk_sys, .io_addr, .io_rd_n, .io_wr_n, .io_wdata);
    rtcc_ctrl uut (.clk_sys, .nrst, .io_addr, .io_rd_n, .io_wr_n, .io_wdata, .io_rdata, .io_rdata_oe, .osc_32k,
        .vcc_ok, .backup_battery_good, .aux_supply, .kick_in_n, .wake_event, .cur_time, .alarm_time, .mode,
        .irq_out_n, .power_out_n, .power_out_oe);

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [6:0] i, input logic [7:0] e);
        exq.push_back(e);
        host.rd(i);
    endtask : rd

    task automatic pins(input logic p, input logic q);
        repeat (6) @(posedge clk_sys);
        chk("power_out_n", 8'(p), 8'(power_out_n));
        chk("irq_out_n", 8'(q), 8'(irq_out_n));
    endtask : pins

    task automatic final_report;
        // A read that never answered leaves its note behind
        if (exq.size() != 0) failures++;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    // Read data judged once, at the start of each read
    always @(posedge clk_sys) begin
        oe_q <= io_rdata_oe;
        if (io_rdata_oe && !oe_q && exq.size() > 0) chk("rdata", exq.pop_front(), io_rdata);
    end

    initial begin
        // About 70k cycles expected; give up at 90k
        #450_000;
        failures++;
        final_report;
    end

    initial begin
        n = $urandom(37178);
        repeat (4) @(posedge clk_sys);
        #1 nrst = 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(IDX_A, 8'h20);
        rd(IDX_B, 8'h00);
        rd(IDX_XA, 8'h00);
        host.wr(IDX_C, 8'hff);
        host.wr(IDX_D, 8'hff);
        rd(IDX_C, 8'h00);
        rd(IDX_D, 8'h80);
        #1 backup_battery_good = 1'b0;
        rd(IDX_D, 8'h00);
        #1 backup_battery_good = 1'b1;
        host.wr(IDX_A, 8'h30);
        rd(IDX_A, 8'h30);
        rd(IDX_XA, 8'h88);
        rd(IDX_XB, 8'ha9);
        r = 8'($urandom) & 8'h6f;
        host.wr(IDX_B, r);
        chk("mode", {r[2:0], 5'h1e}, mode);
        rd(IDX_B, r & 8'h67);
        host.wr(IDX_B, 8'h10);
        host.wr(IDX_B, 8'h90);
        rd(IDX_B, 8'h80);
        host.wr(IDX_B, 8'h00);
        host.wr(IDX_A, 8'h33);
        rd(IDX_C, 8'h40);
        pins(1'b1, 1'b1);
        host.wr(IDX_B, 8'h40);
        pins(1'b1, 1'b0);
        rd(IDX_C, 8'hc0);
        host.wr(IDX_A, 8'h30);
        rd(IDX_C, 8'hc0);
        rd(IDX_C, 8'h00);
        pins(1'b1, 1'b1);
        host.wr(IDX_B, 8'h00);
        host.wr(IDX_XB, 8'h0b);
        @(posedge clk_sys);
        #1 wake_event = 1'b1;
        @(posedge clk_sys);
        #1 wake_event = 1'b0;
        pins(1'b0, 1'b0);
        rd(IDX_XA, 8'h82);
        rd(IDX_C, 8'h80);
        rd(IDX_XA, 8'h82);
        // Flag still set at the write edge, so the power bit write loses once
        host.wr(IDX_XA, 8'h08);
        pins(1'b0, 1'b1);
        host.wr(IDX_XA, 8'h08);
        pins(1'b1, 1'b1);
        #1 kick_in_n = 1'b0;
        pins(1'b0, 1'b0);
        #1 kick_in_n = 1'b1;
        rd(IDX_XA, 8'h81);
        host.wr(IDX_XA, 8'h08);
        pins(1'b0, 1'b1);
        host.wr(IDX_XA, 8'h08);
        host.wr(IDX_XB, 8'h00);
        @(posedge clk_sys);
        #1 wake_event = 1'b1;
        @(posedge clk_sys);
        #1 wake_event = 1'b0;
        pins(1'b1, 1'b1);
        rd(IDX_XA, 8'h8a);
        host.wr(IDX_XA, 8'h09);
        rd(IDX_XA, 8'h89);
        host.wr(IDX_XA, 8'h08);
        host.wr(IDX_A, 8'h50);
        #1 vcc_ok = 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("power_out_oe", 8'h00, 8'(power_out_oe));
        host.wr(IDX_A, 8'h00);
        #1 vcc_ok = 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(IDX_A, 8'h30);
        host.wr(IDX_XB, 8'h08);
        #1 vcc_ok = 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("power_out_oe", 8'h01, 8'(power_out_oe));
        #1 vcc_ok = 1'b1;
        repeat (8) @(posedge clk_sys);
        // All alarm bytes are don't-care, so any time matches
        #1 cur_time = 24'($urandom);
        alarm_time = 24'hc0c0c0 | 24'($urandom);
        host.wr(IDX_A, 8'h60);
        host.wr(IDX_B, 8'h10);
        host.wr(IDX_A, 8'h20);
        n = 0;
        while (irq_out_n !== 1'b0 && n < 80000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("first_update", 8'h01, 8'(n > 66000 && n < 68500));
        rd(IDX_C, 8'hb0);
        final_report;
    end
endmodule : rtcc_ctrl_bench
